/* rtl/brownout_power_monitor.sv */
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bpm_defs.svh"

module brownout_power_monitor #(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic power_on_rst_n,
	input wire logic supply_below_level,
	output logic detector_enable,
	output logic level_select_out,
	output logic cpu_reset_req,
	output logic brownout_irq_req,
	output logic irq,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	localparam logic [`GUARD_CNT_W-1:0] GUARD_LOAD = `GUARD_CNT_W'(`GUARD_WINDOW_CYC);

	function automatic logic addr_is(
		input logic [ADDR_W-1:0] a,
		input logic [7:0] idx
	);
		return a[ADDR_W-1:2] == (ADDR_W-2)'(idx);
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return addr_is(a, `PCON_IDX) | addr_is(a, `PMC_IDX) |
			addr_is(a, `CFG_IDX) | addr_is(a, `GUARD_IDX) |
			addr_is(a, `IEN_IDX) | addr_is(a, `STAT_IDX) |
			addr_is(a, `MASK_IDX);
	endfunction

	// bus state
	logic aw_held_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic w_held_r;
	logic [7:0] wbyte_r;
	logic wlane_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic wr_go;
	logic wr_en;
	logic rd_go;
	logic [7:0] rd_byte;

	// register state
	logic cold_start_flag_r;
	logic por_prev_r;
	logic [7:0] cfg_r;
	logic detector_on_r;
	logic level_select_r;
	logic reset_on_brownout_r;
	logic brownout_event_flag_r;
	logic [7:0] ien_r;
	logic [`STAT_W-1:0] stat_r;
	logic [`STAT_W-1:0] stat_nxt;
	logic [`STAT_W-1:0] mask_r;
	bpm_pkg::guard_state_t guard_state_r;
	logic [`GUARD_CNT_W-1:0] guard_cnt_r;
	bpm_pkg::det_state_t det_state_r;
	logic cpu_reset_r;

	logic supply_above_level;
	logic ev_fall;
	logic ev_rise;
	logic wr_pcon;
	logic wr_pmc;
	logic wr_pmc_ok;
	logic wr_cfg;
	logic wr_guard;
	logic wr_ien;
	logic wr_mask;
	logic rd_stat;

	// comparator is asynchronous to aclk
	level_sync #(
		.RESET_VAL(1'b1)
	) u_supply_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(~supply_below_level),
		.sync_out(supply_above_level)
	);

	// write channels are held independently, either may arrive first
	assign awready = ~aw_held_r & ~bvalid_r;
	assign wready = ~w_held_r & ~bvalid_r;
	assign wr_go = aw_held_r & w_held_r & ~bvalid_r;
	assign wr_en = wr_go & wlane_r & mapped(awaddr_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r <= '0;
		end else if (awvalid && awready) begin
			aw_held_r <= 1'b1;
			awaddr_r <= awaddr;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
		end else if (wvalid && wready) begin
			w_held_r <= 1'b1;
			wbyte_r <= wdata[7:0];
			wlane_r <= wstrb[0];
		end else if (wr_go) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= mapped(awaddr_r) ? `RESP_OKAY : `RESP_DECERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	assign wr_pcon = wr_en & addr_is(awaddr_r, `PCON_IDX);
	assign wr_pmc = wr_en & addr_is(awaddr_r, `PMC_IDX);
	assign wr_cfg = wr_en & addr_is(awaddr_r, `CFG_IDX);
	assign wr_guard = wr_en & addr_is(awaddr_r, `GUARD_IDX);
	assign wr_ien = wr_en & addr_is(awaddr_r, `IEN_IDX);
	assign wr_mask = wr_en & addr_is(awaddr_r, `MASK_IDX);

	// read side answers one cycle after the address is taken
	assign arready = ~rvalid_r;
	assign rd_go = arvalid & arready;
	assign rd_stat = rd_go & addr_is(araddr, `STAT_IDX);

	always_comb begin
		rd_byte = 8'h00;
		if (addr_is(araddr, `PCON_IDX)) begin
			rd_byte[`PCON_COLD] = cold_start_flag_r;
		end else if (addr_is(araddr, `PMC_IDX)) begin
			rd_byte[`PMC_DET_ON] = detector_on_r;
			rd_byte[`PMC_LEVEL] = level_select_r;
			rd_byte[`PMC_RST_ON] = reset_on_brownout_r;
			rd_byte[`PMC_FLAG] = brownout_event_flag_r;
			rd_byte[`PMC_ABOVE] = supply_above_level;
		end else if (addr_is(araddr, `CFG_IDX)) begin
			rd_byte = cfg_r;
		end else if (addr_is(araddr, `GUARD_IDX)) begin
			rd_byte[0] = (guard_state_r == bpm_pkg::GRD_OPEN);
		end else if (addr_is(araddr, `IEN_IDX)) begin
			rd_byte[`IEN_BROWN] = ien_r[`IEN_BROWN];
			rd_byte[`IEN_GLOBAL] = ien_r[`IEN_GLOBAL];
		end else if (addr_is(araddr, `STAT_IDX)) begin
			rd_byte[`STAT_W-1:0] = stat_r;
		end else if (addr_is(araddr, `MASK_IDX)) begin
			rd_byte[`STAT_W-1:0] = mask_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RESP_OKAY;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rdata_r <= {24'h00_0000, rd_byte};
			rresp_r <= mapped(araddr) ? `RESP_OKAY : `RESP_DECERR;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// cold flag survives warm resets, power-on sets it and a write of zero to it clears it
	always_ff @(posedge aclk) begin
		if (!power_on_rst_n) begin
			por_prev_r <= 1'b0;
			cold_start_flag_r <= 1'b0;
		end else begin
			por_prev_r <= 1'b1;
			if (!por_prev_r) begin
				cold_start_flag_r <= 1'b1;
			end else if (wr_pcon && !wbyte_r[`PCON_COLD]) begin
				cold_start_flag_r <= 1'b0;
			end
		end
	end

	// stands in for the non-volatile byte, erased state after power-on
	always_ff @(posedge aclk) begin
		if (!power_on_rst_n) begin
			cfg_r <= `CFG_RESET;
		end else if (wr_cfg) begin
			cfg_r <= wbyte_r;
		end
	end

	// unlock: key one then key two opens a short window for one write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			guard_state_r <= bpm_pkg::GRD_IDLE;
			guard_cnt_r <= '0;
		end else begin
			case (guard_state_r)
				bpm_pkg::GRD_IDLE: begin
					if (wr_guard && wbyte_r == `GUARD_KEY1) begin
						guard_state_r <= bpm_pkg::GRD_KEYED;
					end
				end
				bpm_pkg::GRD_KEYED: begin
					if (wr_guard && wbyte_r == `GUARD_KEY2) begin
						guard_state_r <= bpm_pkg::GRD_OPEN;
						guard_cnt_r <= GUARD_LOAD;
					end else if (wr_en) begin
						guard_state_r <= bpm_pkg::GRD_IDLE;
					end
				end
				bpm_pkg::GRD_OPEN: begin
					guard_cnt_r <= guard_cnt_r - `GUARD_CNT_W'(1);
					if (wr_pmc || guard_cnt_r == '0) begin
						guard_state_r <= bpm_pkg::GRD_IDLE;
					end
				end
				default: begin
					guard_state_r <= bpm_pkg::GRD_IDLE;
				end
			endcase
		end
	end

	assign wr_pmc_ok = wr_pmc & (guard_state_r == bpm_pkg::GRD_OPEN);

	// control bits reload from the configuration byte at every warm reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			detector_on_r <= ~cfg_r[`CFG_DET_OFF];
			level_select_r <= ~cfg_r[`CFG_LEVEL];
			reset_on_brownout_r <= cfg_r[`CFG_RST];
		end else if (wr_pmc_ok) begin
			detector_on_r <= wbyte_r[`PMC_DET_ON];
			level_select_r <= wbyte_r[`PMC_LEVEL];
			reset_on_brownout_r <= wbyte_r[`PMC_RST_ON];
		end
	end

	// bit two is not stored, so a stray one there has no effect
	assign detector_enable = detector_on_r;
	assign level_select_out = level_select_r;

	// crossing tracker, idle while detection is off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			det_state_r <= bpm_pkg::DET_OFF;
		end else begin
			case (det_state_r)
				bpm_pkg::DET_OFF: begin
					if (detector_on_r) begin
						det_state_r <= supply_above_level ?
							bpm_pkg::DET_ABOVE : bpm_pkg::DET_BELOW;
					end
				end
				bpm_pkg::DET_ABOVE: begin
					if (!detector_on_r) begin
						det_state_r <= bpm_pkg::DET_OFF;
					end else if (!supply_above_level) begin
						det_state_r <= bpm_pkg::DET_BELOW;
					end
				end
				bpm_pkg::DET_BELOW: begin
					if (!detector_on_r) begin
						det_state_r <= bpm_pkg::DET_OFF;
					end else if (supply_above_level) begin
						det_state_r <= bpm_pkg::DET_ABOVE;
					end
				end
				default: begin
					det_state_r <= bpm_pkg::DET_OFF;
				end
			endcase
		end
	end

	// enabling while already low gives no event: no crossing was seen
	assign ev_fall = (det_state_r == bpm_pkg::DET_ABOVE) & detector_on_r &
		~supply_above_level;
	assign ev_rise = (det_state_r == bpm_pkg::DET_BELOW) & detector_on_r &
		supply_above_level;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cpu_reset_r <= 1'b0;
		end else begin
			cpu_reset_r <= ev_fall & reset_on_brownout_r;
		end
	end

	assign cpu_reset_req = cpu_reset_r;

	// flag outlives warm resets, but a fall that causes a brown-out reset does not set it
	always_ff @(posedge aclk) begin
		if (!power_on_rst_n) begin
			brownout_event_flag_r <= 1'b0;
		end else if ((ev_fall && !reset_on_brownout_r) || ev_rise) begin
			brownout_event_flag_r <= 1'b1;
		end else if (wr_pmc_ok && !wbyte_r[`PMC_FLAG]) begin
			brownout_event_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ien_r <= 8'h00;
		end else if (wr_ien) begin
			ien_r <= wbyte_r;
		end
	end

	assign brownout_irq_req = brownout_event_flag_r & ien_r[`IEN_BROWN] &
		ien_r[`IEN_GLOBAL];

	// sticky events, a read clears them but a new event wins
	always_comb begin
		stat_nxt = stat_r;
		if (rd_stat) begin
			stat_nxt = '0;
		end
		if (ev_fall) begin
			stat_nxt[`STAT_FALL] = 1'b1;
		end
		if (ev_rise) begin
			stat_nxt[`STAT_RISE] = 1'b1;
		end
		if (ev_fall && reset_on_brownout_r) begin
			stat_nxt[`STAT_RST] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_r <= '0;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_r <= '0;
		end else if (wr_mask) begin
			mask_r <= wbyte_r[`STAT_W-1:0];
		end
	end

	assign irq = |(stat_r & mask_r);

endmodule

`default_nettype wire

/* rtl/bpm_defs.svh */
`ifndef BPM_DEFS_SVH
`define BPM_DEFS_SVH

// register indices, byte address is four times the index
`define PCON_IDX 8'h87
`define PMC_IDX 8'ha3
`define CFG_IDX 8'ha4
`define GUARD_IDX 8'ha5
`define IEN_IDX 8'ha6
`define STAT_IDX 8'ha7
`define MASK_IDX 8'ha8

// power control fields
`define PCON_COLD 4

// power monitor control fields
`define PMC_DET_ON 7
`define PMC_LEVEL 6
`define PMC_RST_ON 4
`define PMC_FLAG 3
`define PMC_ABOVE 0

// configuration byte fields and erased value
`define CFG_DET_OFF 7
`define CFG_LEVEL 6
`define CFG_RST 4
`define CFG_RESET 8'hff

// interrupt enable fields
`define IEN_BROWN 5
`define IEN_GLOBAL 7

// sticky status fields
`define STAT_FALL 0
`define STAT_RISE 1
`define STAT_RST 2
`define STAT_W 3

// guard unlock keys, written in this order
`define GUARD_KEY1 8'haa
`define GUARD_KEY2 8'h55

// timing
`define CLK_PERIOD_NS 50
`define GUARD_WINDOW_NS 800
`define GUARD_WINDOW_CYC ((`GUARD_WINDOW_NS) / (`CLK_PERIOD_NS))
`define GUARD_CNT_W 5

// bus responses
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

/* rtl/bpm_pkg.sv */
package bpm_pkg;

	typedef enum logic [2:0] {
		DET_OFF = 3'b001,
		DET_ABOVE = 3'b010,
		DET_BELOW = 3'b100
	} det_state_t;

	typedef enum logic [2:0] {
		GRD_IDLE = 3'b001,
		GRD_KEYED = 3'b010,
		GRD_OPEN = 3'b100
	} guard_state_t;

endpackage

/* rtl/level_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic async_in,
	output logic sync_out
);

	logic meta_r;
	logic sync_r;

	// first stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= RESET_VAL;
			sync_r <= RESET_VAL;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule

`default_nettype wire

/* testbench/bpm_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module bpm_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic power_on_rst_n,
	input wire logic supply_below_level,
	input wire logic detector_enable,
	input wire logic level_select_out,
	input wire logic cpu_reset_req,
	input wire logic irq,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_rst_pulse: assert property (cpu_reset_req |=> !cpu_reset_req)
		else $error("reset request longer than one cycle");
	chk_rst_cause: assert property (cpu_reset_req |->
		$past(detector_enable, 2) && $past(supply_below_level, 3))
		else $error("reset request without enabled drop");
	chk_det_init: assert property ($rose(power_on_rst_n) |->
		!detector_enable && !level_select_out)
		else $error("control bits not loaded from erased config");
	chk_write_lat: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response missing");
	chk_read_lat: assert property (arvalid && arready |=> rvalid)
		else $error("read response missing");
	chk_b_once: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
	chk_r_once: assert property (rvalid && rready |=> !rvalid)
		else $error("read response repeated");
	chk_ar_block: assert property (rvalid |-> !arready)
		else $error("read address taken during response");
	chk_aw_block: assert property (bvalid |-> !awready && !wready)
		else $error("write taken during response");
	cover property (cpu_reset_req);
	cover property (irq);
	cover property (rvalid && rready);
endmodule
bind brownout_power_monitor bpm_checker chk_i (.aclk(aclk), .aresetn(aresetn),
	.power_on_rst_n(power_on_rst_n), .supply_below_level(supply_below_level),
	.detector_enable(detector_enable), .level_select_out(level_select_out),
	.cpu_reset_req(cpu_reset_req), .irq(irq), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
`default_nettype wire

/* testbench/supply_model.sv */
`timescale 1ns/1ps
`default_nettype none
module supply_model (
	input wire logic aclk,
	input wire logic drop,
	input wire logic cpu_reset_req,
	output logic supply_below_level,
	output int n_resets
);
	initial supply_below_level = 1'b0;
	initial n_resets = 0;
	// comparator moves 7 ns after the clock edge that drives drop, not on it
	always @(drop) supply_below_level <= #7 drop;
	always @(posedge aclk) if (cpu_reset_req) n_resets <= n_resets + 1;
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bpm_defs.svh"
module tb;
	logic aclk = 1'b0, aresetn = 1'b0, power_on_rst_n = 1'b0, drop = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h1;
	logic [1:0] bresp, rresp, r;
	logic [7:0] v;
	logic supply_below_level, detector_enable, level_select_out, cpu_reset_req;
	logic brownout_irq_req, irq, awready, wready, bvalid, arready, rvalid;
	int n_fail = 0, n_compared = 0, n_resets, cyc = 0;
	always #25 aclk = ~aclk;
	supply_model far (.aclk, .drop, .cpu_reset_req, .supply_below_level, .n_resets);
	brownout_power_monitor uut (.aclk, .aresetn, .power_on_rst_n, .supply_below_level,
		.detector_enable, .level_select_out, .cpu_reset_req, .brownout_irq_req, .irq,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// bit outputs looked at mid-cycle, where they are settled
	task automatic chb(input string nm, input logic e, input logic s);
		@(negedge aclk);
		chk(nm, {7'h0, e}, {7'h0, s});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// pending flags, not the driven nets: those update only after the edge
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic pa, pw, pb, ha, hw, hb;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		@(posedge aclk);
		awaddr <= {2'b00, i, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pb) begin
			@(negedge aclk);
			ha = pa && awready;
			hw = pw && wready;
			hb = bvalid;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
			pa = pa && !ha;
			pw = pw && !hw;
			pb = !hb;
		end
	endtask
	task automatic rd(input logic [7:0] i, output logic [7:0] d, output logic [1:0] rs);
		logic pa, pb, ha, hb;
		pa = 1'b1;
		pb = 1'b1;
		@(posedge aclk);
		araddr <= {2'b00, i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (pb) begin
			@(negedge aclk);
			ha = pa && arready;
			hb = rvalid;
			if (hb) d = rdata[7:0];
			if (hb) rs = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
			if (hb) rready <= 1'b0;
			pa = pa && !ha;
			pb = !hb;
		end
	endtask
	task automatic pmc_wr(input logic [7:0] d);
		wr(`GUARD_IDX, `GUARD_KEY1);
		wr(`GUARD_IDX, `GUARD_KEY2);
		wr(`PMC_IDX, d);
	endtask
	task automatic set_drop(input logic x);
		@(posedge aclk);
		drop <= x;
		wt(8);
	endtask
	task automatic t_power_on;
		chb("det_on", 1'b0, detector_enable);
		chb("level", 1'b0, level_select_out);
		rd(`PCON_IDX, v, r);
		chk("cold", 8'h10, v & 8'h10);
		wr(`PCON_IDX, 8'h00);
		rd(`PCON_IDX, v, r);
		chk("cold_clr", 8'h00, v & 8'h10);
		rd(`PMC_IDX, v, r);
		chk("pmc", 8'h11, v);
		rd(8'hff, v, r);
		chk("unmapped", 8'h03, {6'h0, r});
		chk("unmapped_data", 8'h00, v);
		wr(8'hff, 8'h00);
		chk("bresp_unmapped", 8'h03, {6'h0, bresp});
	endtask
	task automatic t_config;
		wr(`CFG_IDX, 8'h00);
		wstrb <= 4'h0;
		wr(`CFG_IDX, 8'hff);
		wstrb <= 4'h1;
		chk("bresp_ok", 8'h00, {6'h0, bresp});
		rd(`CFG_IDX, v, r);
		chk("cfg_lane", 8'h00, v);
		@(posedge aclk);
		aresetn <= 1'b0;
		wt(2);
		aresetn <= 1'b1;
		chb("det_on", 1'b1, detector_enable);
		chb("level", 1'b1, level_select_out);
		rd(`PMC_IDX, v, r);
		chk("pmc", 8'hc1, v);
	endtask
	task automatic t_irq_mode;
		wr(`IEN_IDX, 8'ha0);
		wr(`MASK_IDX, 8'h03);
		set_drop(1'b1);
		rd(`PMC_IDX, v, r);
		chk("flag_fall", 8'h08, v & 8'h09);
		chk("no_reset", 8'h00, 8'(n_resets));
		chb("irq_req", 1'b1, brownout_irq_req);
		chb("irq_on", 1'b1, irq);
		rd(`STAT_IDX, v, r);
		chk("stat", 8'h01, v);
		chb("irq_off", 1'b0, irq);
		pmc_wr(8'hc0);
		wt(8);
		rd(`PMC_IDX, v, r);
		chk("flag_clr", 8'h00, v & 8'h08);
		chb("irq_req", 1'b0, brownout_irq_req);
		set_drop(1'b0);
		wt(20);
		rd(`PMC_IDX, v, r);
		chk("flag_rise", 8'h09, v & 8'h09);
		wr(`IEN_IDX, 8'h20);
		chb("irq_req", 1'b0, brownout_irq_req);
		pmc_wr(8'hc0);
	endtask
	task automatic t_guard_reset;
		wr(`PMC_IDX, 8'h80);
		chb("locked", 1'b1, level_select_out);
		pmc_wr(8'h90);
		chb("unlocked", 1'b0, level_select_out);
		set_drop(1'b1);
		chk("resets", 8'h01, 8'(n_resets));
		rd(`STAT_IDX, v, r);
		chk("stat_rst", 8'h04, v & 8'h04);
		set_drop(1'b0);
		pmc_wr(8'h10);
		set_drop(1'b1);
		chk("det_off", 8'h01, 8'(n_resets));
		set_drop(1'b0);
	endtask
	initial begin
		wt(20);
		aresetn <= 1'b1;
		power_on_rst_n <= 1'b1;
		wt(2);
		t_power_on();
		t_config();
		t_irq_mode();
		t_guard_reset();
		close_out();
	end
endmodule
`default_nettype wire
